// ### hdl/fbpe_consts.vh
// constants for the flash command-sequence host controller
// assumes a 50 MHz clock and a word-wide parallel NOR flash on the pins
`ifndef FBPE_CONSTS_VH
`define FBPE_CONSTS_VH

// apb register offsets (byte addresses)
`define FBPE_OFF_CTRL   8'h00
`define FBPE_OFF_ADDR   8'h04
`define FBPE_OFF_COUNT  8'h08
`define FBPE_OFF_DATA   8'h0C
`define FBPE_OFF_STATUS 8'h10
`define FBPE_OFF_RDATA  8'h14

// ctrl fields
`define FBPE_CTRL_CMD   3:0
`define FBPE_CTRL_ACCEL 8
`define FBPE_CTRL_HWRST 9

// host operation codes written to ctrl
`define FBPE_OP_NONE    4'h0
`define FBPE_OP_BUFPROG 4'h1
`define FBPE_OP_CHIPERS 4'h2
`define FBPE_OP_SUSPEND 4'h3
`define FBPE_OP_RESUME  4'h4
`define FBPE_OP_ABORTRS 4'h5
`define FBPE_OP_BYPPROG 4'h6
`define FBPE_OP_READ    4'h7
`define FBPE_OP_RESET   4'h8
`define FBPE_OP_POLL    4'h9

// flash unlock addresses and data, reset and bypass-program commands
`define FBPE_UNLK_A1    23'h000555
`define FBPE_UNLK_A2    23'h0002AA
`define FBPE_UNLK_D1    16'h00AA
`define FBPE_UNLK_D2    16'h0055
`define FBPE_CMD_RESET  16'h00F0
`define FBPE_CMD_BYPPRG 16'h00A0

// status bit positions on the data bus
`define FBPE_ST_POLL    7
`define FBPE_ST_TOGGLE  6
`define FBPE_ST_TMO     5
`define FBPE_ST_ABORT   1

// status register fields
`define FBPE_SR_BUSY    0
`define FBPE_SR_ABORT   1
`define FBPE_SR_TMO     2
`define FBPE_SR_REFUSED 3
`define FBPE_SR_SUSP    4
`define FBPE_SR_LOCKED  5

// timing
`define FBPE_CLK_NS     20
`define FBPE_SUSP_NS    15000
`define FBPE_SUSP_CYC   ((`FBPE_SUSP_NS + `FBPE_CLK_NS - 1) / `FBPE_CLK_NS)

`define FBPE_BUF_WORDS  16
`endif

// ### hdl/fbpe_bus_cycle.v
// one asynchronous flash bus cycle, write or read, on the flash pins
// assumes start only while idle; dq input arrives from outside the clock
`default_nettype none
module fbpe_bus_cycle #(
  parameter SETUP = 2,
  parameter PULSE = 4,
  parameter HOLD  = 3
) (
  // clock and reset
  input  wire        clock,
  input  wire        reset_n,
  // request
  input  wire        start,
  input  wire        isWrite,
  input  wire [22:0] addrIn,
  input  wire [15:0] dataIn,
  output wire        done,
  output reg  [15:0] rdata_q,
  // flash pins
  output reg  [22:0] flashAddr_q,
  output reg  [15:0] dqOut_q,
  input  wire [15:0] dqIn,
  output reg         dqOe_q,
  output reg         flashCeN_q,
  output reg         flashWeN_q,
  output reg         flashOeN_q
);
  localparam S_IDLE  = 2'd0;
  localparam S_SETUP = 2'd1;
  localparam S_PULSE = 2'd2;
  localparam S_HOLD  = 2'd3;

  reg [1:0]  state_q;
  reg [3:0]  cnt_q;
  reg        wr_q;
  reg [15:0] dqMeta_q;
  reg [15:0] dqSync_q;

  assign done = (state_q == S_HOLD) && (cnt_q == 4'd0);

  always @(posedge clock) begin
    dqMeta_q <= dqIn;
    dqSync_q <= dqMeta_q;
  end

  always @(posedge clock) begin
    if (!reset_n) begin
      state_q     <= S_IDLE;
      cnt_q       <= 4'h0;
      wr_q        <= 1'b0;
      rdata_q     <= 16'h0000;
      flashAddr_q <= 23'h000000;
      dqOut_q     <= 16'h0000;
      dqOe_q      <= 1'b0;
      flashCeN_q  <= 1'b1;
      flashWeN_q  <= 1'b1;
      flashOeN_q  <= 1'b1;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (start) begin
            state_q     <= S_SETUP;
            cnt_q       <= SETUP[3:0] - 4'd1;
            wr_q        <= isWrite;
            flashAddr_q <= addrIn;
            dqOut_q     <= dataIn;
            dqOe_q      <= isWrite;
            flashCeN_q  <= 1'b0;
          end
        end
        S_SETUP: begin
          if (cnt_q == 4'd0) begin
            state_q    <= S_PULSE;
            cnt_q      <= PULSE[3:0] - 4'd1;
            flashWeN_q <= ~wr_q;
            flashOeN_q <= wr_q;
          end else begin
            cnt_q <= cnt_q - 4'd1;
          end
        end
        S_PULSE: begin
          if (cnt_q == 4'd0) begin
            state_q    <= S_HOLD;
            cnt_q      <= HOLD[3:0] - 4'd1;
            flashWeN_q <= 1'b1;
            if (!wr_q) begin
              rdata_q <= dqSync_q;
            end
          end else begin
            cnt_q <= cnt_q - 4'd1;
          end
        end
        default: begin
          // read data is caught before the final hold edge, because done
          // is seen by the caller at that very edge
          if (cnt_q == 4'd0) begin
            state_q    <= S_IDLE;
            dqOe_q     <= 1'b0;
            flashCeN_q <= 1'b1;
            flashOeN_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 4'd1;
            if (!wr_q) begin
              rdata_q <= dqSync_q;
            end
          end
        end
      endcase
    end
  end
endmodule // fbpe_bus_cycle
`default_nettype wire

// ### hdl/fbpe_host_ctl.v
// host controller for a parallel nor flash: buffered and bypass program,
// suspend and resume, chip erase, abort reset, status polling; apb slave
// assumes apb on the same clock and the flash pins wired straight through
`include "fbpe_consts.vh"
`default_nettype none
// Function
// - two unlocks then buffer-load at sector
// - fourth cycle writes sector and count minus one
// - all loads stay in first page
// - confirm at sector after all loads
// - poll last loaded address for status bits
// - after abort, three-cycle abort reset required
// - chip erase is six write cycles
module fbpe_host_ctl #(
  parameter [15:0] CMD_BUFLOAD = 16'h0025,
  parameter [15:0] CMD_CONFIRM = 16'h0029,
  parameter [15:0] CMD_ERSETUP = 16'h0080,
  parameter [15:0] CMD_CHIPERS = 16'h0010,
  parameter [15:0] CMD_SUSPEND = 16'h00B0,
  parameter [15:0] CMD_RESUME  = 16'h0030,
  parameter        SUSP_CYC    = `FBPE_SUSP_CYC
) (
  // clock and reset
  input  wire        clock,
  input  wire        reset_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // flash pins
  output wire [22:0] flashAddr,
  output wire [15:0] dqOut,
  input  wire [15:0] dqIn,
  output wire        dqOe,
  output wire        flashCeN,
  output wire        flashWeN,
  output wire        flashOeN,
  output wire        flashResetN,
  output wire        protectAccelHighVolt
);
  localparam S_IDLE  = 3'd0;
  localparam S_ISSUE = 3'd1;
  localparam S_WAIT  = 3'd2;
  localparam S_POLLA = 3'd3;
  localparam S_POLLB = 3'd4;
  localparam S_SUSP  = 3'd5;

  reg [15:0] buf_q [0:`FBPE_BUF_WORDS-1];
  reg [3:0]  wrPtr_q;
  reg [2:0]  state_q;
  reg [3:0]  op_q;
  reg [4:0]  step_q;
  reg [22:0] addr_q;
  reg [3:0]  count_q;
  reg [22:0] pollAddr_q;
  reg [15:0] prev_q;
  reg [15:0] rdReg_q;
  reg        accel_q;
  reg        hwRst_q;
  reg        abortSeen_q;
  reg        tmoSeen_q;
  reg        refused_q;
  reg        susp_q;
  reg        locked_q;
  reg [9:0]  suspCnt_q;

  reg        stepWr;
  reg [22:0] stepAddr;
  reg [15:0] stepData;
  reg        busStart;
  reg        busWr;
  reg [22:0] busAddr;
  wire       busDone;
  wire [15:0] busRdata;

  wire apbAcc = psel && penable;
  wire apbWr  = apbAcc && pwrite;
  wire mapped = (paddr[1:0] == 2'b00) && (paddr <= `FBPE_OFF_RDATA);
  wire [3:0] newOp = pwdata[`FBPE_CTRL_CMD];
  wire busy = (state_q != S_IDLE);
  wire [22:0] pageBase = {addr_q[22:4], 4'h0};

  assign pready  = 1'b1;
  assign pslverr = apbAcc && !mapped;
  assign flashResetN = ~hwRst_q;
  assign protectAccelHighVolt = accel_q;

  // last step index of each sequence
  function [4:0] last_step;
    input [3:0] op;
    input [3:0] cnt;
    begin
      case (op)
        `FBPE_OP_BUFPROG: last_step = 5'd5 + {1'b0, cnt};
        `FBPE_OP_CHIPERS: last_step = 5'd5;
        `FBPE_OP_ABORTRS: last_step = 5'd2;
        `FBPE_OP_BYPPROG: last_step = 5'd1;
        default:          last_step = 5'd0;
      endcase
    end
  endfunction

  // opens a program sequence with the standard two unlock cycles
  function [39:0] unlock_step;
    input [4:0] st;
    begin
      if (st == 5'd0)
        unlock_step = {1'b1, `FBPE_UNLK_A1, `FBPE_UNLK_D1};
      else
        unlock_step = {1'b1, `FBPE_UNLK_A2, `FBPE_UNLK_D2};
    end
  endfunction

  always @* begin
    {stepWr, stepAddr, stepData} = {1'b1, addr_q, 16'h0000};
    case (op_q)
      `FBPE_OP_BUFPROG: begin
        if (step_q < 5'd2)
          {stepWr, stepAddr, stepData} = unlock_step(step_q);
        else if (step_q == 5'd2)
          stepData = CMD_BUFLOAD;
        else if (step_q == 5'd3)
          stepData = {12'h000, count_q};
        else if (step_q == 5'd5 + {1'b0, count_q})
          stepData = CMD_CONFIRM;
        else begin
          // loads stay in the page of the first address
          stepAddr = pageBase | {19'h00000, step_q[3:0] - 4'd4};
          stepData = buf_q[step_q[3:0] - 4'd4];
        end
      end
      `FBPE_OP_CHIPERS: begin
        case (step_q)
          5'd0, 5'd3: {stepWr, stepAddr, stepData} = unlock_step(5'd0);
          5'd1, 5'd4: {stepWr, stepAddr, stepData} = unlock_step(5'd1);
          5'd2: {stepAddr, stepData} = {`FBPE_UNLK_A1, CMD_ERSETUP};
          default: {stepAddr, stepData} = {`FBPE_UNLK_A1, CMD_CHIPERS};
        endcase
      end
      `FBPE_OP_ABORTRS: begin
        if (step_q < 5'd2)
          {stepWr, stepAddr, stepData} = unlock_step(step_q);
        else
          {stepAddr, stepData} = {`FBPE_UNLK_A1, `FBPE_CMD_RESET};
      end
      `FBPE_OP_BYPPROG: begin
        if (step_q == 5'd0)
          stepData = `FBPE_CMD_BYPPRG;
        else
          stepData = buf_q[0];
      end
      `FBPE_OP_SUSPEND: stepData = CMD_SUSPEND;
      `FBPE_OP_RESUME:  stepData = CMD_RESUME;
      `FBPE_OP_RESET:   stepData = `FBPE_CMD_RESET;
      default:          stepWr = 1'b0;
    endcase
  end

  always @* begin
    busStart = (state_q == S_ISSUE) || (state_q == S_POLLA);
    busWr    = (state_q == S_ISSUE) && stepWr;
    busAddr  = (state_q == S_POLLA) ? pollAddr_q : stepAddr;
  end

  always @(posedge clock) begin
    if (apbWr && paddr == `FBPE_OFF_DATA) begin
      buf_q[wrPtr_q] <= pwdata[15:0];
    end
  end

  always @(posedge clock) begin
    if (!reset_n) begin
      state_q     <= S_IDLE;
      op_q        <= `FBPE_OP_NONE;
      step_q      <= 5'd0;
      addr_q      <= 23'h000000;
      count_q     <= 4'h0;
      wrPtr_q     <= 4'h0;
      pollAddr_q  <= 23'h000000;
      prev_q      <= 16'h0000;
      rdReg_q     <= 16'h0000;
      accel_q     <= 1'b0;
      hwRst_q     <= 1'b0;
      abortSeen_q <= 1'b0;
      tmoSeen_q   <= 1'b0;
      refused_q   <= 1'b0;
      susp_q      <= 1'b0;
      locked_q    <= 1'b0;
      suspCnt_q   <= 10'h000;
    end else begin
      if (apbWr && paddr == `FBPE_OFF_ADDR && !busy)
        addr_q <= pwdata[22:0];
      if (apbWr && paddr == `FBPE_OFF_COUNT && !busy)
        count_q <= pwdata[3:0];
      if (apbWr && paddr == `FBPE_OFF_DATA)
        wrPtr_q <= wrPtr_q + 4'd1;
      if (apbWr && paddr == `FBPE_OFF_CTRL) begin
        accel_q <= pwdata[`FBPE_CTRL_ACCEL];
        hwRst_q <= pwdata[`FBPE_CTRL_HWRST];
        if (pwdata[`FBPE_CTRL_HWRST]) begin
          susp_q   <= 1'b0;
          locked_q <= 1'b0;
        end
        if (newOp != `FBPE_OP_NONE && !busy) begin
          // after an abort, operations other than abort reset, poll and read are refused until the abort reset or a hardware reset write to ctrl
          if (locked_q && newOp != `FBPE_OP_ABORTRS &&
              newOp != `FBPE_OP_POLL && newOp != `FBPE_OP_READ) begin
            refused_q <= 1'b1;
          end else if (newOp == `FBPE_OP_BYPPROG && !accel_q) begin
            refused_q <= 1'b1;
          end else begin
            refused_q <= 1'b0;
            op_q      <= newOp;
            step_q    <= 5'd0;
            state_q   <= (newOp == `FBPE_OP_POLL) ? S_POLLA : S_ISSUE;
          end
        end
      end
      case (state_q)
        S_IDLE: ;
        S_ISSUE: state_q <= S_WAIT;
        S_WAIT: begin
          if (busDone) begin
            if (step_q != last_step(op_q, count_q)) begin
              step_q  <= step_q + 5'd1;
              state_q <= S_ISSUE;
            end else begin
              state_q <= S_IDLE;
              wrPtr_q <= 4'h0;
              case (op_q)
                `FBPE_OP_BUFPROG:
                  pollAddr_q <= pageBase | {19'h00000, count_q};
                `FBPE_OP_BYPPROG: pollAddr_q <= addr_q;
                `FBPE_OP_CHIPERS: pollAddr_q <= addr_q;
                `FBPE_OP_READ:    rdReg_q <= busRdata;
                `FBPE_OP_ABORTRS: begin
                  locked_q    <= 1'b0;
                  abortSeen_q <= 1'b0;
                end
                `FBPE_OP_RESET:   tmoSeen_q <= 1'b0;
                `FBPE_OP_RESUME:  susp_q <= 1'b0;
                `FBPE_OP_SUSPEND: begin
                  suspCnt_q <= SUSP_CYC[9:0];
                  state_q   <= S_SUSP;
                end
                default: ;
              endcase
            end
          end
        end
        S_POLLA: begin
          state_q <= S_POLLB;
        end
        S_POLLB: begin
          if (busDone) begin
            rdReg_q <= busRdata;
            prev_q  <= busRdata;
            if (step_q == 5'd0) begin
              step_q  <= 5'd1;
              state_q <= S_POLLA;
            end else if (busRdata[`FBPE_ST_TOGGLE] ==
                         prev_q[`FBPE_ST_TOGGLE]) begin
              state_q <= S_IDLE;
            end else if (busRdata[`FBPE_ST_ABORT] &&
                         prev_q[`FBPE_ST_ABORT]) begin
              // both reads must show it: the step from status to array
              // data can look like a toggle with a stray bit set
              abortSeen_q <= 1'b1;
              locked_q    <= 1'b1;
              state_q     <= S_IDLE;
            end else if (busRdata[`FBPE_ST_TMO] &&
                         prev_q[`FBPE_ST_TMO]) begin
              tmoSeen_q <= 1'b1;
              state_q   <= S_IDLE;
            end else begin
              state_q <= S_POLLA;
              step_q  <= 5'd1;
            end
          end
        end
        S_SUSP: begin
          // the device may take the full suspend time before reads are valid
          if (suspCnt_q == 10'h000) begin
            susp_q  <= 1'b1;
            state_q <= S_IDLE;
          end else begin
            suspCnt_q <= suspCnt_q - 10'd1;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  always @* begin
    prdata = 32'h00000000;
    if (apbAcc && !pwrite) begin
      case (paddr)
        `FBPE_OFF_CTRL: begin
          prdata[`FBPE_CTRL_CMD]   = op_q;
          prdata[`FBPE_CTRL_ACCEL] = accel_q;
          prdata[`FBPE_CTRL_HWRST] = hwRst_q;
        end
        `FBPE_OFF_ADDR:  prdata = {9'h000, addr_q};
        `FBPE_OFF_COUNT: prdata = {28'h0000000, count_q};
        `FBPE_OFF_DATA:  prdata = {28'h0000000, wrPtr_q};
        `FBPE_OFF_STATUS: begin
          prdata[`FBPE_SR_BUSY]    = busy;
          prdata[`FBPE_SR_ABORT]   = abortSeen_q;
          prdata[`FBPE_SR_TMO]     = tmoSeen_q;
          prdata[`FBPE_SR_REFUSED] = refused_q;
          prdata[`FBPE_SR_SUSP]    = susp_q;
          prdata[`FBPE_SR_LOCKED]  = locked_q;
          prdata[31:16]            = rdReg_q;
        end
        `FBPE_OFF_RDATA: prdata = {16'h0000, rdReg_q};
        default: prdata = 32'h00000000;
      endcase
    end
  end

  fbpe_bus_cycle u_cycle (
    .clock       (clock),
    .reset_n     (reset_n),
    .start       (busStart),
    .isWrite     (busWr),
    .addrIn      (busAddr),
    .dataIn      (stepData),
    .done        (busDone),
    .rdata_q     (busRdata),
    .flashAddr_q (flashAddr),
    .dqOut_q     (dqOut),
    .dqIn        (dqIn),
    .dqOe_q      (dqOe),
    .flashCeN_q  (flashCeN),
    .flashWeN_q  (flashWeN),
    .flashOeN_q  (flashOeN)
  );
endmodule // fbpe_host_ctl
`default_nettype wire

// ### dv/fbpe_flash_model.sv
// behavioural nor flash: command decode, buffer checks, status bits
// assumes the controller's registered pins, sampled on the bench clock
`default_nettype none
module fbpe_flash_model #(
  parameter int BUSY_READS = 3
) (
  // clock
  input  wire logic        clock,
  // flash pins
  input  wire logic [22:0] flashAddr,
  input  wire logic [15:0] dqOut,
  input  wire logic        flashCeN,
  input  wire logic        flashWeN,
  input  wire logic        flashOeN,
  input  wire logic        flashResetN,
  input  wire logic        protectAccelHighVolt,
  output wire logic [15:0] dqIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [22:0] la[$];
  logic [15:0] ld[$];
  logic [79:0] h;
  logic [15:0] rd, lastD;
  logic [22:0] rdA;
  logic [7:0]  sec;
  logic [18:0] page;
  logic        weQ, oeQ, abt, susp, ers, tog, first, forceAbt;
  int          ph, n, busy;
  // a released bus shows the inverse, so a stale copy never passes
  assign dqIn = (!flashCeN && !flashOeN) ? rd : ~rd;
  initial begin
    {h, rd, lastD, rdA, sec, page} = '0;
    {abt, susp, ers, tog, first, forceAbt} = '0;
    weQ = 1;
    oeQ = 1;
    ph = 0;
    busy = 0;
  end
  task automatic abort();
    abt = 1;
    ph = 0;
  endtask
  task automatic go(input logic e);
    busy = BUSY_READS;
    ers = e;
    susp = 0;
  endtask
  task automatic wr(input logic [22:0] a, input logic [15:0] d);
    la.push_back(a);
    ld.push_back(d);
    if (busy > 0) begin
      if (!ers && d == 16'h00B0) susp = 1;
      if (!ers && d == 16'h0030) susp = 0;
    end else if (abt) begin
      if (h[31:0] == 32'h00AA0055 && d == 16'h00F0) abt = 0;
    end else if (ph == 1) begin
      if (d > 16'd15 || a[22:15] != sec) abort();
      else begin
        n = d + 1;
        ph = 2;
        first = 1;
      end
    end else if (ph == 2) begin
      if (first) page = a[22:4];
      first = 0;
      if (a[22:15] != sec || a[22:4] != page) abort();
      else begin
        n--;
        lastD = d;
        if (n == 0) ph = 3;
      end
    end else if (ph == 3) begin
      ph = 0;
      if (d == 16'h0029 && a[22:15] == sec && !forceAbt) go(0);
      else abort();
    end else if (ph == 4) begin
      ph = 0;
      lastD = d;
      go(0);
    end else if (d == 16'h0025 && h[31:0] == 32'h00AA0055) begin
      sec = a[22:15];
      ph = 1;
    end else if (d == 16'h0010 && h == 80'h00AA0055008000AA0055) begin
      lastD = 16'h0000;
      go(1);
    end else if (d == 16'h00A0 && protectAccelHighVolt) ph = 4;
    h = {h[63:0], d};
  endtask
  task automatic rdSt(input logic [22:0] a);
    rdA = a;
    if (abt || (busy > 0 && !susp)) begin
      tog = ~tog;
      rd = {8'h00, ~lastD[7], tog, 3'b000, ers & tog, abt, 1'b0};
      if (!abt) busy--;
    end else rd = a[15:0];
  endtask
  always @(posedge clock) begin
    weQ <= flashWeN;
    oeQ <= flashOeN;
    if (!flashResetN) begin
      busy = 0;
      abt = 0;
      susp = 0;
      ph = 0;
    end else if (flashWeN && !weQ && !flashCeN) wr(flashAddr, dqOut);
    else if (!flashOeN && oeQ && !flashCeN) rdSt(flashAddr);
  end
endmodule // fbpe_flash_model
`default_nettype wire

// ### dv/fbpe_host_ctl_assertions.sv
// port checker for the flash host controller, bound to its top
// assumes one clock domain and the apb/flash pins as ports
`default_nettype none
module fbpe_host_ctl_assertions (
  // clock and reset
  input wire logic        clock,
  input wire logic        reset_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // flash pins
  input wire logic [22:0] flashAddr,
  input wire logic        dqOe,
  input wire logic        flashCeN,
  input wire logic        flashWeN,
  input wire logic        flashOeN,
  input wire logic        flashResetN,
  input wire logic        protectAccelHighVolt
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  wire acc = psel && penable;
  wire bad = paddr > 8'h14 || paddr[1:0] != 2'b00;
  wire ctl = acc && pwrite && paddr == 8'h00;
  wire w8 = pwdata[8];
  wire w9 = pwdata[9];
  ready_always_a: assert property (acc |-> pready)
    else $error("pready low in access");
  slverr_map_a: assert property (acc |-> pslverr == bad)
    else $error("pslverr wrong for address");
  rdata_idle_a: assert property (!(acc && !pwrite) |-> prdata == 32'h0)
    else $error("prdata not zero outside read");
  strobe_excl_a: assert property (!(!flashWeN && !flashOeN))
    else $error("write and read strobes together");
  ce_setup_a: assert property ($fell(flashCeN) |->
    (flashWeN && flashOeN)[*2] ##1 (!flashWeN || !flashOeN))
    else $error("strobe setup not two clocks");
  we_pulse_a: assert property ($fell(flashWeN) |->
    (!flashWeN && !flashCeN)[*4] ##1 flashWeN)
    else $error("write pulse not four clocks");
  addr_hold_a: assert property (!flashCeN && !$past(flashCeN) |->
    $stable(flashAddr))
    else $error("address moved within a cycle");
  we_drive_a: assert property (!flashWeN |-> dqOe && !flashCeN)
    else $error("data not driven under write");
  oe_float_a: assert property (!flashOeN |-> !dqOe)
    else $error("data driven during read");
  accel_pin_a: assert property (ctl |=>
    protectAccelHighVolt == $past(w8))
    else $error("accel pin not from ctrl");
  hw_reset_a: assert property (ctl |=> flashResetN == !$past(w9))
    else $error("reset pin not from ctrl");
endmodule // fbpe_host_ctl_assertions
bind fbpe_host_ctl fbpe_host_ctl_assertions u_chk (.clock, .reset_n,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .flashAddr, .dqOe, .flashCeN, .flashWeN, .flashOeN, .flashResetN,
  .protectAccelHighVolt);
`default_nettype wire

// ### dv/fbpe_host_ctl_tb.sv
// bench for the flash host controller: apb master, flash model, checks
// assumes the design pins wired straight to the behavioural flash model
`default_nettype none
module fbpe_host_ctl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, reset_n, psel, penable, pwrite, pready, pslverr;
  logic        se, oe, ce, we, oen, rstn, hv, accel;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r, seed;
  logic [22:0] fa, a;
  logic [15:0] dqo, dqi, d;
  logic [3:0]  c;
  int          errors, checks;
  logic [22:0] ea[$];
  logic [15:0] ed[$];
  fbpe_host_ctl #(.SUSP_CYC(5)) dut (.clock, .reset_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .flashAddr(fa),
    .dqOut(dqo), .dqIn(dqi), .dqOe(oe), .flashCeN(ce), .flashWeN(we),
    .flashOeN(oen), .flashResetN(rstn), .protectAccelHighVolt(hv));
  fbpe_flash_model fm (.clock, .flashAddr(fa), .dqOut(dqo), .flashCeN(ce),
    .flashWeN(we), .flashOeN(oen), .flashResetN(rstn),
    .protectAccelHighVolt(hv), .dqIn(dqi));
  initial begin
    clock = 0;
    forever #10 clock = ~clock;
  end
  task automatic final_report();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // entered just after a rising edge; one idle clock follows each transfer
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] v);
    int k;
    k = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= v;
    @(posedge clock);
    penable <= 1;
    @(posedge clock);
    // answer is taken at the same edge that samples pready high
    while (pready !== 1'b1 && k < 50) begin
      @(posedge clock);
      k++;
    end
    r = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clock);
    if (k == 50) begin
      errors++;
      final_report();
    end
  endtask
  task automatic op(input logic [3:0] o);
    int k;
    apb(1, 8'h00, {22'h0, 1'b0, accel, 4'h0, o});
    for (k = 0; k < 300; k++) begin
      apb(0, 8'h10, 32'h0);
      if (r[0] === 1'b0) break;
    end
    if (k == 300) begin
      errors++;
      final_report();
    end
  endtask
  task automatic ex(input logic [22:0] xa, input logic [15:0] xd);
    ea.push_back(xa);
    ed.push_back(xd);
  endtask
  task automatic seqChk();
    cmp(32'(fm.la.size()), 32'(ea.size()));
    foreach (ea[i]) if (i < fm.la.size()) begin
      cmp({9'h0, fm.la[i]}, {9'h0, ea[i]});
      cmp({16'h0, fm.ld[i]}, {16'h0, ed[i]});
    end
    ea.delete();
    ed.delete();
    fm.la.delete();
    fm.ld.delete();
  endtask
  task automatic bufProg(input logic [22:0] pa, input logic [3:0] pc);
    apb(1, 8'h04, {9'h0, pa});
    apb(1, 8'h08, {28'h0, pc});
    ex(23'h555, 16'h00AA);
    ex(23'h2AA, 16'h0055);
    ex(pa, 16'h0025);
    ex(pa, {12'h0, pc});
    for (int i = 0; i <= pc; i++) begin
      d = 16'($random(seed));
      apb(1, 8'h0C, {16'h0, d});
      ex({pa[22:4], 4'(i)}, d);
    end
    ex(pa, 16'h0029);
    op(4'h1);
  endtask
  initial begin
    seed = 32'h3790;
    {reset_n, psel, penable, pwrite, paddr, pwdata, accel} = '0;
    {errors, checks} = '0;
    repeat (4) @(posedge clock);
    reset_n <= 1;
    @(posedge clock);
    apb(0, 8'h10, 32'h0);
    cmp(r, 32'h0);
    apb(0, 8'h18, 32'h0);
    cmp({31'h0, se}, 32'h1);
    $display("test regs done");
    for (int t = 0; t < 5; t++) begin
      a = 23'($random(seed));
      c = (t == 0) ? 4'h0 : (t == 1) ? 4'hF : 4'($random(seed));
      bufProg(a, c);
      seqChk();
      op(4'h9);
      cmp({9'h0, fm.rdA}, {9'h0, a[22:4], c});
      cmp({26'h0, r[5:0]}, 32'h0);
    end
    $display("test buffer program done");
    fm.forceAbt = 1;
    bufProg(a, 4'h2);
    fm.forceAbt = 0;
    seqChk();
    op(4'h9);
    cmp({30'h0, r[5], r[1]}, 32'h3);
    op(4'h1);
    cmp({31'h0, r[3]}, 32'h1);
    ex(23'h555, 16'h00AA);
    ex(23'h2AA, 16'h0055);
    ex(23'h555, 16'h00F0);
    op(4'h5);
    seqChk();
    cmp({30'h0, r[5], fm.abt}, 32'h0);
    $display("test abort done");
    bufProg(a, 4'h3);
    ex(a, 16'h00B0);
    op(4'h3);
    cmp({30'h0, r[4], fm.susp}, 32'h3);
    op(4'h7);
    apb(0, 8'h14, 32'h0);
    cmp(r, {16'h0, a[15:0]});
    ex(a, 16'h0030);
    op(4'h4);
    cmp({31'h0, r[4]}, 32'h0);
    op(4'h9);
    seqChk();
    $display("test suspend done");
    ex(23'h555, 16'h00AA);
    ex(23'h2AA, 16'h0055);
    ex(23'h555, 16'h0080);
    ex(23'h555, 16'h00AA);
    ex(23'h2AA, 16'h0055);
    ex(23'h555, 16'h0010);
    op(4'h2);
    ex(a, 16'h00F0);
    op(4'h8);
    seqChk();
    cmp({31'h0, fm.busy > 0}, 32'h1);
    apb(1, 8'h00, 32'h200);
    // one more edge so the model has seen the reset pin before we look
    @(posedge clock);
    cmp({30'h0, rstn, fm.busy > 0}, 32'h0);
    apb(1, 8'h00, 32'h0);
    cmp({31'h0, rstn}, 32'h1);
    $display("test erase done");
    op(4'h6);
    cmp({31'h0, r[3]}, 32'h1);
    accel = 1;
    apb(1, 8'h00, 32'h100);
    cmp({31'h0, hv}, 32'h1);
    d = 16'($random(seed));
    apb(1, 8'h0C, {16'h0, d});
    ex(a, 16'h00A0);
    ex(a, d);
    op(4'h6);
    seqChk();
    op(4'h9);
    cmp({26'h0, r[5:0]}, 32'h0);
    $display("test bypass done");
    final_report();
  end
endmodule // fbpe_host_ctl_tb
`default_nettype wire
